// *** fcs_map.vh ***
// Operation
// - Ready flag is 0 during automatic program or erase, 1 when it finishes.
// - Ready and both error flags are mirrored into flash mode register A.
// - Status byte: D7 ready, D5 erase error, D4 program error, rest reserved.
// - In erase-write mode zero, reads after read-status return the status byte.
// - In mode zero, reads after program or erase return status until read-array.
// - Clear-status command resets both error flags and their mirror bits.
// - Program and block erase are refused while either error flag is set.
// - Any error sets the applicable error flags to 1.
// - An incorrectly written command sets both error flags.
// - Erase second write other than confirm or read-array sets both flags.
// - Program or erase to the first block while rewriting is disabled sets both flags.
// - Program or erase to an unmapped address sets both flags.
// - Program or erase to a locked block sets both flags.
// - Failed automatic erase sets erase error only.
// - Failed automatic program sets program error only.
// - Read-array code as erase second write drops the pending erase.
`ifndef FCS_MAP_VH
`define FCS_MAP_VH

`define FCS_CMD_READ_ARRAY   8'hFF
`define FCS_CMD_READ_STATUS  8'h70
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_PROGRAM      8'h40
`define FCS_CMD_ERASE        8'h20
`define FCS_CMD_CONFIRM      8'hD0

`define FCS_SR_READY         7
`define FCS_SR_ERASE_ERR     5
`define FCS_SR_PROG_ERR      4

`define FCS_FMRA_READY       0
`define FCS_FMRA_PROG_FAIL   6
`define FCS_FMRA_ERASE_FAIL  7

`define FCS_SR_RESET         8'h80
`define FCS_FMRA_RESET       8'h01

`define FCS_BLK0_BASE        16'hE000
`define FCS_BLK0_LAST        16'hEFFF
`define FCS_BLK1_BASE        16'hF000
`define FCS_BLK1_LAST        16'hFFFF

`define FCS_OP_LIMIT         32'd1000000

`endif

// *** fcs_op_track.v ***
`timescale 1ns/1ps
`include "fcs_map.vh"
module fcs_op_track #(
	parameter LIMIT = `FCS_OP_LIMIT,
	parameter CW    = 20
) (
	// Clock and reset
	input  wire        mclk_i,
	input  wire        rst_b_i,
	// Launch and array answer
	input  wire        start_i,
	input  wire        array_done_i,
	input  wire        array_fail_i,
	// Outcome
	output reg         busy_o,
	output reg         done_o,
	output reg         fail_o
);
	reg [CW-1:0] cnt;

	always @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			fail_o <= 1'b0;
			cnt    <= {CW{1'b0}};
		end
		else
		begin
			done_o <= 1'b0;
			fail_o <= 1'b0;
			if (start_i && !busy_o)
			begin
				busy_o <= 1'b1;
				cnt    <= {CW{1'b0}};
			end
			else if (busy_o)
			begin
				cnt <= cnt + 1'b1;
				if (array_done_i)
				begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
					fail_o <= array_fail_i;
				end
				// A stuck array would otherwise hold the sequencer busy forever
				else if (cnt == LIMIT[CW-1:0] - 1'b1)
				begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
					fail_o <= 1'b1;
				end
			end
		end
	end
endmodule

// *** fcs_seq.v ***
`timescale 1ns/1ps
`include "fcs_map.vh"
module fcs_seq #(
	parameter AW       = 16,
	parameter OP_LIMIT = `FCS_OP_LIMIT,
	parameter CW       = 20
) (
	// Clock and reset
	input  wire          mclk_i,
	input  wire          rst_b_i,
	// CPU bus
	input  wire          bus_wr_i,
	input  wire          bus_rd_i,
	input  wire [AW-1:0] bus_addr_i,
	input  wire [7:0]    bus_wdata_i,
	output reg  [7:0]    rd_data_o,
	output reg           rd_valid_o,
	// Control bits
	input  wire          erase_write_mode_zero_i,
	input  wire          global_rewrite_enable_i,
	input  wire          first_block_lock_i,
	input  wire          second_block_lock_i,
	// Flash array
	input  wire [7:0]    array_rdata_i,
	input  wire          array_done_i,
	input  wire          array_fail_i,
	output reg           prog_start_o,
	output reg           erase_start_o,
	output reg  [AW-1:0] op_addr_o,
	output reg  [7:0]    op_data_o,
	// Status views
	output reg  [7:0]    flash_op_status_o,
	output reg  [7:0]    flash_mode_reg_a_o
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_PROG  = 2'd1;
	localparam ST_ERASE = 2'd2;

	reg [1:0]    state;
	reg [AW-1:0] first_addr;
	reg          status_mode;
	reg          op_is_erase;
	reg          seq_ready_flag;
	reg          erase_error_flag;
	reg          program_error_flag;

	wire busy;
	wire op_done;
	wire op_fail;

	// Returns {mapped, block index}
	function [1:0] blk_of;
		input [AW-1:0] a;
		begin
			if (a >= `FCS_BLK0_BASE && a <= `FCS_BLK0_LAST)
				blk_of = 2'b10;
			else if (a >= `FCS_BLK1_BASE && a <= `FCS_BLK1_LAST)
				blk_of = 2'b11;
			else
				blk_of = 2'b00;
		end
	endfunction

	// True when a program or erase at this address must be rejected
	function target_bad;
		input [AW-1:0] a;
		input          gre;
		input          lk0;
		input          lk1;
		reg   [1:0]    b;
		begin
			b = blk_of(a);
			target_bad = !b[1]
				|| (!b[0] && (!gre || lk0))
				|| (b[0] && lk1);
		end
	endfunction

	function [7:0] status_byte;
		input rdy;
		input ee;
		input pe;
		begin
			status_byte = 8'h00;
			status_byte[`FCS_SR_READY]    = rdy;
			status_byte[`FCS_SR_ERASE_ERR] = ee;
			status_byte[`FCS_SR_PROG_ERR]  = pe;
		end
	endfunction

	wire cmd_wr  = bus_wr_i && !busy;
	wire err_any = erase_error_flag || program_error_flag;

	reg next_launch_prog;
	reg next_launch_erase;
	reg next_seq_err;
	reg next_clear;
	reg next_status_mode;
	reg [1:0] next_state;
	reg next_ee;
	reg next_pe;
	reg next_ready;

	always @*
	begin
		next_launch_prog  = 1'b0;
		next_launch_erase = 1'b0;
		next_seq_err      = 1'b0;
		next_clear        = 1'b0;
		next_status_mode  = status_mode;
		next_state        = state;
		if (cmd_wr)
		begin
			case (state)
				ST_IDLE:
				begin
					case (bus_wdata_i)
						`FCS_CMD_READ_ARRAY:   next_status_mode = 1'b0;
						`FCS_CMD_READ_STATUS:  next_status_mode = 1'b1;
						`FCS_CMD_CLEAR_STATUS: next_clear = 1'b1;
						`FCS_CMD_PROGRAM:      next_state = ST_PROG;
						`FCS_CMD_ERASE:        next_state = ST_ERASE;
						default:               next_seq_err = 1'b1;
					endcase
				end
				ST_PROG:
				begin
					next_state = ST_IDLE;
					if (err_any)
						next_seq_err = 1'b0;
					else if (bus_addr_i != first_addr)
						next_seq_err = 1'b1;
					else if (target_bad(bus_addr_i, global_rewrite_enable_i,
						first_block_lock_i, second_block_lock_i))
						next_seq_err = 1'b1;
					else
					begin
						next_launch_prog = 1'b1;
						next_status_mode = erase_write_mode_zero_i | status_mode;
					end
				end
				ST_ERASE:
				begin
					next_state = ST_IDLE;
					if (bus_wdata_i == `FCS_CMD_READ_ARRAY)
						next_status_mode = 1'b0;
					else if (bus_wdata_i != `FCS_CMD_CONFIRM)
						next_seq_err = 1'b1;
					else if (err_any)
						next_seq_err = 1'b0;
					else if (target_bad(bus_addr_i, global_rewrite_enable_i,
						first_block_lock_i, second_block_lock_i))
						next_seq_err = 1'b1;
					else
					begin
						next_launch_erase = 1'b1;
						next_status_mode  = erase_write_mode_zero_i | status_mode;
					end
				end
				default: next_state = ST_IDLE;
			endcase
		end
		// Error sets win over a same-cycle clear; flags otherwise hold
		next_ee = (erase_error_flag && !next_clear) || next_seq_err
			|| (op_fail && op_is_erase);
		next_pe = (program_error_flag && !next_clear) || next_seq_err
			|| (op_fail && !op_is_erase);
		if (next_launch_prog || next_launch_erase)
			next_ready = 1'b0;
		else if (op_done)
			next_ready = 1'b1;
		else
			next_ready = seq_ready_flag;
	end

	always @(posedge mclk_i)
	begin
		if (!rst_b_i)
		begin
			state              <= ST_IDLE;
			first_addr         <= {AW{1'b0}};
			status_mode        <= 1'b0;
			op_is_erase        <= 1'b0;
			seq_ready_flag     <= 1'b1;
			erase_error_flag   <= 1'b0;
			program_error_flag <= 1'b0;
			prog_start_o       <= 1'b0;
			erase_start_o      <= 1'b0;
			op_addr_o          <= {AW{1'b0}};
			op_data_o          <= 8'h00;
			rd_data_o          <= 8'h00;
			rd_valid_o         <= 1'b0;
			flash_op_status_o  <= `FCS_SR_RESET;
			flash_mode_reg_a_o <= `FCS_FMRA_RESET;
		end
		else
		begin
			state              <= next_state;
			status_mode        <= next_status_mode;
			seq_ready_flag     <= next_ready;
			erase_error_flag   <= next_ee;
			program_error_flag <= next_pe;
			prog_start_o       <= next_launch_prog;
			erase_start_o      <= next_launch_erase;
			if (cmd_wr && state == ST_IDLE)
				first_addr <= bus_addr_i;
			if (next_launch_prog || next_launch_erase)
			begin
				op_is_erase <= next_launch_erase;
				op_addr_o   <= bus_addr_i;
				op_data_o   <= bus_wdata_i;
			end
			flash_op_status_o <= status_byte(next_ready, next_ee, next_pe);
			flash_mode_reg_a_o                       <= 8'h00;
			flash_mode_reg_a_o[`FCS_FMRA_READY]      <= next_ready;
			flash_mode_reg_a_o[`FCS_FMRA_ERASE_FAIL] <= next_ee;
			flash_mode_reg_a_o[`FCS_FMRA_PROG_FAIL]  <= next_pe;
			rd_valid_o <= bus_rd_i;
			if (bus_rd_i)
			begin
				// Status mode only redirects reads in erase-write mode zero
				if (erase_write_mode_zero_i && status_mode)
					rd_data_o <= status_byte(seq_ready_flag, erase_error_flag,
						program_error_flag);
				else
					rd_data_o <= array_rdata_i;
			end
		end
	end

	fcs_op_track #(
		.LIMIT (OP_LIMIT),
		.CW    (CW)
	) u_track (
		.mclk_i       (mclk_i),
		.rst_b_i      (rst_b_i),
		.start_i      (prog_start_o | erase_start_o),
		.array_done_i (array_done_i),
		.array_fail_i (array_fail_i),
		.busy_o       (busy),
		.done_o       (op_done),
		.fail_o       (op_fail)
	);
endmodule

// *** fcs_seq_chk.sv ***
`timescale 1ns/1ps
module fcs_seq_chk (
	// Clock and reset
	input wire       mclk_i,
	input wire       rst_b_i,
	// Bus and array
	input wire       bus_wr_i,
	input wire       bus_rd_i,
	input wire       array_done_i,
	input wire       array_fail_i,
	// Outputs watched
	input wire       rd_valid_o,
	input wire       prog_start_o,
	input wire       erase_start_o,
	input wire [7:0] flash_op_status_o,
	input wire [7:0] flash_mode_reg_a_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	reg        last_erase;
	wire [7:0] st;
	assign st = flash_op_status_o;
	always @(posedge mclk_i)
		if (prog_start_o || erase_start_o)
			last_erase <= erase_start_o;
	read_answer_a: assert property (bus_rd_i |=> rd_valid_o)
		else $error("read answer missing");
	reserved_zero_a: assert property (st[6] == 1'b0 && st[3:0] == 4'h0)
		else $error("reserved status bits set");
	mirror_bits_a: assert property (flash_mode_reg_a_o == {st[5], st[4], 5'h00, st[7]})
		else $error("mirror bits differ");
	busy_start_a: assert property ((prog_start_o || erase_start_o) |-> !st[7])
		else $error("ready high at launch");
	ready_back_a: assert property (array_done_i && !st[7] |-> ##2 st[7])
		else $error("ready not back");
	fail_kind_a: assert property (array_done_i && array_fail_i && !st[7] |->
		##2 st[5:4] == (last_erase ? 2'b10 : 2'b01)) else $error("wrong fail flag");
	err_hold_a: assert property (st[5:4] != 2'b00 && !bus_wr_i |=> st[5:4] == $past(st[5:4]))
		else $error("error flag lost");
	err_refuse_a: assert property (st[5] || st[4] |-> !(prog_start_o || erase_start_o))
		else $error("launch with error set");
	reset_value_a: assert property ($rose(rst_b_i) |-> st == 8'h80 && flash_mode_reg_a_o == 8'h01)
		else $error("bad reset value");
endmodule
bind fcs_seq fcs_seq_chk u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_wr_i(bus_wr_i),
	.bus_rd_i(bus_rd_i), .array_done_i(array_done_i), .array_fail_i(array_fail_i),
	.rd_valid_o(rd_valid_o), .prog_start_o(prog_start_o), .erase_start_o(erase_start_o),
	.flash_op_status_o(flash_op_status_o), .flash_mode_reg_a_o(flash_mode_reg_a_o));

// *** fcs_array_model.sv ***
`timescale 1ns/1ps
module fcs_array_model #(
	parameter DLY = 6
) (
	// Clock and reset
	input  wire mclk_i,
	input  wire rst_b_i,
	// Launch and outcome
	input  wire go_i,
	input  wire fail_mode_i,
	output wire done_o,
	output wire fail_o
);
	reg [7:0] cnt;
	always @(posedge mclk_i)
		if (!rst_b_i)
			cnt <= 8'h00;
		else if (go_i)
			cnt <= DLY[7:0];
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
	// One pulse; fail only qualifies it
	assign done_o = (cnt == 8'h01);
	assign fail_o = done_o & fail_mode_i;
endmodule

// *** flash_cmd_status_reporting_tb_top.sv ***
`timescale 1ns/1ps
module flash_cmd_status_reporting_tb_top;
	reg        mclk_i = 0;
	reg        rst_b_i = 0;
	reg        bus_wr_i = 0;
	reg        bus_rd_i = 0;
	reg [15:0] bus_addr_i = 16'h0000;
	reg [7:0]  bus_wdata_i = 8'h00;
	reg        mode0 = 1, gre = 1, lk0 = 0, lk1 = 0, fail_mode = 0;
	// Launch pulses seen right after a write edge; they last one cycle only
	reg [1:0]  last_start = 2'b00;
	wire [7:0] rd_data, op_data, st, fmr;
	wire [15:0] op_addr;
	wire       rd_valid, ps, es, done, fail;
	integer    failures = 0, n_compared = 0, cycles = 0;
	always #2.5 mclk_i = ~mclk_i;
	fcs_seq #(.AW(16), .OP_LIMIT(50)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_addr_i(bus_addr_i),
		.bus_wdata_i(bus_wdata_i), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.erase_write_mode_zero_i(mode0), .global_rewrite_enable_i(gre),
		.first_block_lock_i(lk0), .second_block_lock_i(lk1), .array_rdata_i(~bus_addr_i[7:0]),
		.array_done_i(done), .array_fail_i(fail), .prog_start_o(ps), .erase_start_o(es),
		.op_addr_o(op_addr), .op_data_o(op_data), .flash_op_status_o(st),
		.flash_mode_reg_a_o(fmr));
	fcs_array_model #(.DLY(6)) u_arr (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .go_i(ps | es),
		.fail_mode_i(fail_mode), .done_o(done), .fail_o(fail));
	task finish_test;
	begin
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	task chk8(input [7:0] got, input [7:0] exp);
	begin
		n_compared = n_compared + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [15:0] a, input [7:0] d);
	begin
		bus_addr_i = a;
		bus_wdata_i = d;
		bus_wr_i = 1;
		@(posedge mclk_i) #1 bus_wr_i = 0;
		last_start = {es, ps};
		@(posedge mclk_i) #1;
	end
	endtask
	task rd(input [15:0] a, input [7:0] exp);
	begin
		bus_addr_i = a;
		bus_rd_i = 1;
		@(posedge mclk_i) #1 bus_rd_i = 0;
		chk8({7'h00, rd_valid}, 8'h01);
		chk8(rd_data, exp);
		@(posedge mclk_i) #1;
	end
	endtask
	task wait_ready;
		integer i;
	begin
		for (i = 0; i < 100 && st[7] !== 1'b1; i = i + 1)
			@(posedge mclk_i) #1;
		chk8(st & 8'h80, 8'h80);
	end
	endtask
	task two_op(input [7:0] c, input [15:0] a, input [7:0] d, input f, input [7:0] exp);
	begin
		fail_mode = f;
		wr(a, c);
		wr(a, d);
		chk8({6'h00, last_start}, c == 8'h20 ? 8'h02 : 8'h01);
		chk8(op_addr[7:0], a[7:0]);
		chk8(st, 8'h00);
		rd(16'hE123, 8'h00);
		wait_ready;
		chk8(st, exp);
		chk8(fmr, {exp[5], exp[4], 5'h00, exp[7]});
		$display("test op %h done", c);
	end
	endtask
	task seq_case(input [7:0] c, input [15:0] a1, input [7:0] d, input [15:0] a2,
		input [2:0] cfg, input [7:0] exp);
	begin
		{gre, lk0, lk1} = cfg;
		wr(a1, c);
		wr(a2, d);
		chk8({6'h00, last_start}, 8'h00);
		chk8(st, exp);
		wr(16'hE000, 8'h50);
		chk8(st, 8'h80);
		chk8(fmr, 8'h01);
		{gre, lk0, lk1} = 3'b100;
		$display("test case %h done", c);
	end
	endtask
	always @(posedge mclk_i)
	begin
		cycles = cycles + 1;
		if (cycles == 5000)
		begin
			failures = failures + 1;
			finish_test;
		end
	end
	initial
	begin
		repeat (4) @(posedge mclk_i);
		#1 rst_b_i = 1;
		chk8(st, 8'h80);
		chk8(fmr, 8'h01);
		two_op(8'h40, 16'hE010, 8'h55, 0, 8'h80);
		chk8(op_data, 8'h55);
		two_op(8'h40, 16'hE020, 8'h66, 1, 8'h90);
		wr(16'hE030, 8'h40);
		wr(16'hE030, 8'h77);
		chk8({6'h00, last_start}, 8'h00);
		wr(16'hF000, 8'h20);
		wr(16'hF100, 8'hD0);
		chk8({6'h00, last_start}, 8'h00);
		chk8(st, 8'h90);
		wr(16'hE000, 8'h50);
		chk8(st, 8'h80);
		two_op(8'h20, 16'hF100, 8'hD0, 1, 8'hA0);
		wr(16'hE000, 8'h50);
		seq_case(8'h33, 16'hE000, 8'hFF, 16'hE000, 3'b100, 8'hB0);
		seq_case(8'h40, 16'hE010, 8'h11, 16'hE011, 3'b100, 8'hB0);
		seq_case(8'h20, 16'hE000, 8'h12, 16'hE000, 3'b100, 8'hB0);
		seq_case(8'h40, 16'hE000, 8'h11, 16'hE000, 3'b000, 8'hB0);
		seq_case(8'h40, 16'h8000, 8'h11, 16'h8000, 3'b100, 8'hB0);
		seq_case(8'h20, 16'h0000, 8'hD0, 16'hF000, 3'b101, 8'hB0);
		seq_case(8'h20, 16'h0000, 8'hD0, 16'hE000, 3'b110, 8'hB0);
		wr(16'hE000, 8'h70);
		seq_case(8'h20, 16'h0000, 8'hFF, 16'hE000, 3'b100, 8'h80);
		rd(16'hE055, 8'hAA);
		wr(16'hE000, 8'h70);
		rd(16'hE055, 8'h80);
		mode0 = 0;
		wr(16'hE000, 8'hFF);
		wr(16'hE000, 8'h70);
		rd(16'hE055, 8'hAA);
		$display("test read done");
		finish_test;
	end
endmodule
